// [hdl/mpio_pkg.sv]
// Purpose: shared constants for the multi port pin logic
// Assumes: apb with 32-bit data, 8-bit byte address
// Notes:   every register is one aligned word, data in the low bits
package mpio_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_B_DATA  = 8'h00;
  localparam logic [7:0] OFF_B_DIR   = 8'h04;
  localparam logic [7:0] OFF_C_DATA  = 8'h08;
  localparam logic [7:0] OFF_C_DIR   = 8'h0c;
  localparam logic [7:0] OFF_D_DATA  = 8'h10;
  localparam logic [7:0] OFF_D_DIR   = 8'h14;
  localparam logic [7:0] OFF_F_DATA  = 8'h18;
  localparam logic [7:0] OFF_F_DIR   = 8'h1c;
  localparam logic [7:0] OFF_G_DATA  = 8'h20;
  localparam logic [7:0] OFF_G_DIR   = 8'h24;
  localparam logic [7:0] OFF_H_DATA  = 8'h28;
  localparam logic [7:0] OFF_H_DIR   = 8'h2c;
  localparam logic [7:0] OFF_J_DATA  = 8'h30;
  localparam logic [7:0] OFF_J_DIR   = 8'h34;
  localparam logic [7:0] OFF_K_DATA  = 8'h38;
  localparam logic [7:0] OFF_K_DIR   = 8'h3c;
  localparam logic [7:0] OFF_E_DATA  = 8'h40;
  localparam logic [7:0] OFF_G_ASSIGN = 8'h44;
  localparam logic [7:0] OFF_PULLUP  = 8'h48;
  localparam logic [7:0] OFF_SYS_OPT = 8'h4c;
  localparam logic [7:0] OFF_SPI_CTL = 8'h50;
  localparam logic [7:0] OFF_SCI_CTL = 8'h54;
  localparam logic [7:0] OFF_MODE    = 8'h58;

  // field positions
  localparam int POS_C_OD     = 0;
  localparam int POS_SPI_OD   = 0;
  localparam int POS_SCI_OD   = 0;
  localparam int POS_PU_B     = 0;
  localparam int POS_PU_F     = 1;
  localparam int POS_PU_H     = 2;
  localparam int POS_PU_G     = 3;

  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] RST_PU    = 4'h0;
  localparam logic [5:0] RST_GASN  = 6'h00;

  // operating mode, latched from the straps
  typedef enum logic [3:0] {
    MPIO_MODE_BOOT   = 4'b0001,
    MPIO_MODE_SINGLE = 4'b0010,
    MPIO_MODE_TEST   = 4'b0100,
    MPIO_MODE_EXP    = 4'b1000
  } mpio_mode_e;

endpackage : mpio_pkg

// [hdl/mpio_port_pins.sv]
// Purpose: pin logic of parallel ports b to k with apb registers
// Assumes: pins synchronous to clk_i, mode straps stable during reset
// Notes:   pready is combinational, read data is captured in setup
//
// Contract
// RULE1: expanded mode drives port b as address 15:8, else general io; the code drives the address in test mode too
// RULE2: port b/f reads return pins; drive only outputs in single/boot
// RULE3: expanded mode uses port c as bidirectional data bus
// RULE4: port c/d reads give pin for inputs, latch for outputs
// RULE5: after reset port c is input in single/boot, bus otherwise
// RULE6: port c open-drain drives low for zero, floats for one
// RULE7: port c open-drain only takes effect in single chip mode
// RULE8: port d general io, spi on 5:2, sci on 1:0
// RULE9: spi bit open-drains d 5:2, sci bit open-drains d 1:0
// RULE10: port d open-drain works in single chip and expanded modes
// RULE11: port e is input only, digital or analog
// RULE12: expanded mode drives port f as address 7:0
// RULE13: pull-ups on b, f, h, g 5:0 enabled by pull-up register
// RULE14: g 7:6 input only; g 5:0 select io or expansion address
// RULE15: port g/h/j/k reads return pins; drive only outputs
// RULE16: port h upper four chip selects, lower four pwm
// RULE17: j and k upper five pins shared with timers
// RULE18: data writes never move a pin held by output compare
// RULE19: j/k come out of reset as inputs; direction bits rule
// RULE20: direction one is output, zero input, all clear at reset
`timescale 1ns/1ps
module mpio_port_pins
  import mpio_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // mode straps
  input  wire logic       mode_a_i,
  input  wire logic       mode_b_i,
  // apb slave
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]     prdata_o,
  output logic            pready_o,
  output logic            pslverr_o,
  // expanded bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  input  wire logic       bus_write_i,
  input  wire logic [5:0] mem_expansion_addr_i,
  output logic [7:0]      bus_rdata_o,
  // peripheral functions
  input  wire logic       spi_en_i,
  input  wire logic [3:0] spi_out_i,
  input  wire logic [3:0] spi_oe_i,
  input  wire logic       sci_en_i,
  input  wire logic [1:0] sci_out_i,
  input  wire logic [1:0] sci_oe_i,
  input  wire logic [3:0] chip_sel_en_i,
  input  wire logic [3:0] chip_sel_i,
  input  wire logic [3:0] pwm_en_i,
  input  wire logic [3:0] pwm_i,
  input  wire logic [4:0] timer2_oc_en_i,
  input  wire logic [4:0] timer2_oc_i,
  input  wire logic [4:0] timer3_oc_en_i,
  input  wire logic [4:0] timer3_oc_i,
  // pins
  input  wire logic [7:0] pb_i,
  output logic [7:0]      pb_o,
  output logic [7:0]      pb_oe_o,
  input  wire logic [7:0] pc_i,
  output logic [7:0]      pc_o,
  output logic [7:0]      pc_oe_o,
  input  wire logic [7:0] pd_i,
  output logic [7:0]      pd_o,
  output logic [7:0]      pd_oe_o,
  input  wire logic [7:0] pe_i,
  input  wire logic [7:0] pf_i,
  output logic [7:0]      pf_o,
  output logic [7:0]      pf_oe_o,
  input  wire logic [7:0] pg_i,
  output logic [7:0]      pg_o,
  output logic [7:0]      pg_oe_o,
  input  wire logic [7:0] ph_i,
  output logic [7:0]      ph_o,
  output logic [7:0]      ph_oe_o,
  input  wire logic [7:0] pj_i,
  output logic [7:0]      pj_o,
  output logic [7:0]      pj_oe_o,
  input  wire logic [7:0] pk_i,
  output logic [7:0]      pk_o,
  output logic [7:0]      pk_oe_o,
  // pull-up enables
  output logic [7:0]      pb_pullup_o,
  output logic [7:0]      pf_pullup_o,
  output logic [7:0]      ph_pullup_o,
  output logic [5:0]      pg_pullup_o,
  // mode status
  output logic [3:0]      mode_o
);
  import mpio_pkg::*;

  mpio_mode_e mode;
  logic [7:0] port_b_data_reg, port_b_direction_reg;
  logic [7:0] port_c_data_reg, port_c_direction_reg;
  logic [7:0] port_d_data_reg, port_d_direction_reg;
  logic [7:0] port_f_data_reg, port_f_direction_reg;
  logic [7:0] port_g_data_reg, port_g_direction_reg;
  logic [7:0] port_h_data_reg, port_h_direction_reg;
  logic [7:0] port_j_data_reg, port_j_direction_reg;
  logic [7:0] port_k_data_reg, port_k_direction_reg;
  logic [5:0] port_g_function_assign_reg;
  logic [3:0] pullup_assign_reg;
  logic       port_c_data_reg_open_drain_en;
  logic       spi_pins_open_drain_en;
  logic       sci_pins_open_drain_en;
  logic [31:0] prdata;
  logic [7:0]  bus_rdata;

  // mode decode
  wire io_mode  = (mode == MPIO_MODE_SINGLE) || (mode == MPIO_MODE_BOOT);
  wire bus_mode = !io_mode;
  wire single   = (mode == MPIO_MODE_SINGLE);
  wire exp_mode = (mode == MPIO_MODE_EXP);

  // apb decode
  wire setup   = psel_i && !penable_i;
  wire access  = psel_i && penable_i;
  wire s_bd = paddr_i == OFF_B_DATA;
  wire s_br = paddr_i == OFF_B_DIR;
  wire s_cd = paddr_i == OFF_C_DATA;
  wire s_cr = paddr_i == OFF_C_DIR;
  wire s_dd = paddr_i == OFF_D_DATA;
  wire s_dr = paddr_i == OFF_D_DIR;
  wire s_fd = paddr_i == OFF_F_DATA;
  wire s_fr = paddr_i == OFF_F_DIR;
  wire s_gd = paddr_i == OFF_G_DATA;
  wire s_gr = paddr_i == OFF_G_DIR;
  wire s_hd = paddr_i == OFF_H_DATA;
  wire s_hr = paddr_i == OFF_H_DIR;
  wire s_jd = paddr_i == OFF_J_DATA;
  wire s_jr = paddr_i == OFF_J_DIR;
  wire s_kd = paddr_i == OFF_K_DATA;
  wire s_kr = paddr_i == OFF_K_DIR;
  wire s_ed = paddr_i == OFF_E_DATA;
  wire s_ga = paddr_i == OFF_G_ASSIGN;
  wire s_pu = paddr_i == OFF_PULLUP;
  wire s_o2 = paddr_i == OFF_SYS_OPT;
  wire s_sp = paddr_i == OFF_SPI_CTL;
  wire s_sc = paddr_i == OFF_SCI_CTL;
  wire s_md = paddr_i == OFF_MODE;
  wire hit  = s_bd | s_br | s_cd | s_cr | s_dd | s_dr | s_fd | s_fr |
              s_gd | s_gr | s_hd | s_hr | s_jd | s_jr | s_kd | s_kr |
              s_ed | s_ga | s_pu | s_o2 | s_sp | s_sc | s_md;
  wire wr   = access && pwrite_i;
  wire [7:0] wb = pwdata_i[7:0];

  // readback: c and d mix latch and pin per bit
  wire [7:0] c_read = (port_c_direction_reg & port_c_data_reg) |
                      (~port_c_direction_reg & pc_i); // RULE4
  wire [7:0] d_read = (port_d_direction_reg & port_d_data_reg) |
                      (~port_d_direction_reg & pd_i); // RULE4
  wire [7:0] rd_byte =
      ({8{s_bd}} & pb_i) | ({8{s_br}} & port_b_direction_reg) | // RULE2
      ({8{s_cd}} & c_read) | ({8{s_cr}} & port_c_direction_reg) |
      ({8{s_dd}} & d_read) | ({8{s_dr}} & port_d_direction_reg) |
      ({8{s_fd}} & pf_i) | ({8{s_fr}} & port_f_direction_reg) | // RULE2
      ({8{s_gd}} & pg_i) | ({8{s_gr}} & port_g_direction_reg) | // RULE15
      ({8{s_hd}} & ph_i) | ({8{s_hr}} & port_h_direction_reg) | // RULE15
      ({8{s_jd}} & pj_i) | ({8{s_jr}} & port_j_direction_reg) | // RULE15
      ({8{s_kd}} & pk_i) | ({8{s_kr}} & port_k_direction_reg) | // RULE15
      ({8{s_ed}} & pe_i) | // RULE11
      ({8{s_ga}} & {2'h0, port_g_function_assign_reg}) |
      ({8{s_pu}} & {4'h0, pullup_assign_reg}) |
      ({8{s_o2}} & {7'h00, port_c_data_reg_open_drain_en}) |
      ({8{s_sp}} & {7'h00, spi_pins_open_drain_en}) |
      ({8{s_sc}} & {7'h00, sci_pins_open_drain_en}) |
      ({8{s_md}} & {4'h0, mode});

  assign pready_o  = access;
  assign pslverr_o = access && !hit;
  assign prdata_o  = prdata;
  assign mode_o    = mode;

  // straps caught on every clock edge during reset, held once reset drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      case ({mode_b_i, mode_a_i})
        2'b00:   mode <= MPIO_MODE_BOOT;
        2'b01:   mode <= MPIO_MODE_TEST;
        2'b10:   mode <= MPIO_MODE_SINGLE;
        default: mode <= MPIO_MODE_EXP;
      endcase
    end
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata    <= 32'h0;
      bus_rdata <= RST_BYTE;
    end else begin
      if (setup && !pwrite_i) begin
        prdata <= {24'h0, rd_byte};
      end
      bus_rdata <= pc_i; // RULE3
    end
  end
  assign bus_rdata_o = bus_rdata;

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_data_reg <= RST_BYTE;
      port_c_data_reg <= RST_BYTE;
      port_d_data_reg <= RST_BYTE;
      port_f_data_reg <= RST_BYTE;
      port_g_data_reg <= RST_BYTE;
      port_h_data_reg <= RST_BYTE;
      port_j_data_reg <= RST_BYTE;
      port_k_data_reg <= RST_BYTE;
      port_b_direction_reg <= RST_BYTE; // RULE20
      port_c_direction_reg <= RST_BYTE; // RULE5
      port_d_direction_reg <= RST_BYTE;
      port_f_direction_reg <= RST_BYTE;
      port_g_direction_reg <= RST_BYTE;
      port_h_direction_reg <= RST_BYTE;
      port_j_direction_reg <= RST_BYTE; // RULE19
      port_k_direction_reg <= RST_BYTE; // RULE19
      port_g_function_assign_reg <= RST_GASN;
      pullup_assign_reg      <= RST_PU;
      port_c_data_reg_open_drain_en    <= 1'b0;
      spi_pins_open_drain_en <= 1'b0;
      sci_pins_open_drain_en <= 1'b0;
    end else if (wr) begin
      if (s_bd) port_b_data_reg <= wb;
      if (s_br) port_b_direction_reg <= wb;
      if (s_cd) port_c_data_reg <= wb;
      if (s_cr) port_c_direction_reg <= wb;
      if (s_dd) port_d_data_reg <= wb;
      if (s_dr) port_d_direction_reg <= wb;
      if (s_fd) port_f_data_reg <= wb;
      if (s_fr) port_f_direction_reg <= wb;
      if (s_gd) port_g_data_reg <= wb;
      if (s_gr) port_g_direction_reg <= {2'h0, wb[5:0]}; // RULE14
      if (s_hd) port_h_data_reg <= wb;
      if (s_hr) port_h_direction_reg <= wb;
      if (s_jd) port_j_data_reg <= wb;
      if (s_jr) port_j_direction_reg <= wb;
      if (s_kd) port_k_data_reg <= wb;
      if (s_kr) port_k_direction_reg <= wb;
      if (s_ga) port_g_function_assign_reg <= wb[5:0];
      if (s_pu) pullup_assign_reg <= wb[3:0];
      if (s_o2) port_c_data_reg_open_drain_en <= wb[POS_C_OD];
      if (s_sp) spi_pins_open_drain_en <= wb[POS_SPI_OD];
      if (s_sc) sci_pins_open_drain_en <= wb[POS_SCI_OD];
    end
  end

  // port b and f: general io only in single/boot, address otherwise
  assign pb_o    = bus_mode ? bus_addr_i[15:8] : port_b_data_reg; // RULE1
  assign pb_oe_o = bus_mode ? 8'hff : port_b_direction_reg; // RULE2
  assign pf_o    = bus_mode ? bus_addr_i[7:0] : port_f_data_reg; // RULE12
  assign pf_oe_o = bus_mode ? 8'hff : port_f_direction_reg; // RULE2

  // port c: data bus, or io with optional open drain
  wire       c_od    = port_c_data_reg_open_drain_en && single; // RULE7
  wire [7:0] c_oe_io = port_c_direction_reg &
                       ~({8{c_od}} & port_c_data_reg); // RULE6
  assign pc_o    = bus_mode ? bus_wdata_i :
                   (c_od ? 8'h00 : port_c_data_reg); // RULE6
  assign pc_oe_o = bus_mode ? {8{bus_write_i}} : c_oe_io; // RULE3

  // port d: spi and sci take their pins when enabled; open drain is
  // honoured in every mode, so the serial lines can share a wire
  wire [7:0] d_raw_o = {port_d_data_reg[7:6],
                        spi_en_i ? spi_out_i : port_d_data_reg[5:2],
                        sci_en_i ? sci_out_i : port_d_data_reg[1:0]}; // RULE8
  wire [7:0] d_raw_oe = {port_d_direction_reg[7:6],
                         spi_en_i ? spi_oe_i : port_d_direction_reg[5:2],
                         sci_en_i ? sci_oe_i
                                  : port_d_direction_reg[1:0]}; // RULE8
  wire [7:0] d_od = {2'b00, {4{spi_pins_open_drain_en}},
                     {2{sci_pins_open_drain_en}}}; // RULE9 RULE10
  assign pd_o    = d_raw_o & ~d_od; // RULE9
  assign pd_oe_o = d_raw_oe & ~(d_od & d_raw_o); // RULE9

  // port g: upper two input only, lower six io or expansion address
  wire [5:0] g_exp = {6{exp_mode}} & port_g_function_assign_reg; // RULE14
  assign pg_o    = {2'b00, (g_exp & mem_expansion_addr_i) |
                   (~g_exp & port_g_data_reg[5:0])}; // RULE14
  assign pg_oe_o = {2'b00, g_exp | port_g_direction_reg[5:0]}; // RULE15

  // port h: chip selects exist only on the expanded bus
  wire [3:0] h_cs = chip_sel_en_i & {4{exp_mode}}; // RULE16
  assign ph_o    = {(h_cs & chip_sel_i) | (~h_cs & port_h_data_reg[7:4]),
                    (pwm_en_i & pwm_i) |
                    (~pwm_en_i & port_h_data_reg[3:0])}; // RULE16
  assign ph_oe_o = {h_cs | port_h_direction_reg[7:4],
                    pwm_en_i | port_h_direction_reg[3:0]}; // RULE15

  // port j and k: output compare owns the pin, latch still updates
  assign pj_o    = {(timer2_oc_en_i & timer2_oc_i) |
                    (~timer2_oc_en_i & port_j_data_reg[7:3]),
                    port_j_data_reg[2:0]}; // RULE17 RULE18
  assign pj_oe_o = {timer2_oc_en_i, 3'b000} | port_j_direction_reg; // RULE19
  assign pk_o    = {(timer3_oc_en_i & timer3_oc_i) |
                    (~timer3_oc_en_i & port_k_data_reg[7:3]),
                    port_k_data_reg[2:0]}; // RULE17 RULE18
  assign pk_oe_o = {timer3_oc_en_i, 3'b000} | port_k_direction_reg; // RULE19

  // pull-ups follow the assignment register
  assign pb_pullup_o = {8{pullup_assign_reg[POS_PU_B]}}; // RULE13
  assign pf_pullup_o = {8{pullup_assign_reg[POS_PU_F]}}; // RULE13
  assign ph_pullup_o = {8{pullup_assign_reg[POS_PU_H]}}; // RULE13
  assign pg_pullup_o = {6{pullup_assign_reg[POS_PU_G]}}; // RULE13

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_setup_s(logic sel);
    setup && !pwrite_i && sel;
  endsequence

  sequence rd_access_s;
    access;
  endsequence

  port_b_addr_a: assert property (exp_mode |-> // RULE1
      pb_o == bus_addr_i[15:8] && pb_oe_o == 8'hff)
    else $error("port b not carrying high address");
  pin_readback_a: assert property (rd_setup_s(s_bd) ##1 rd_access_s // RULE2
      |-> prdata_o[7:0] == $past(pb_i))
    else $error("port b read is not the pin level");
  c_mix_read_a: assert property (rd_setup_s(s_cd) ##1 rd_access_s // RULE4
      |-> prdata_o[7:0] == $past(c_read) && prdata_o[31:8] == 24'h0)
    else $error("port c read mix wrong");
  c_bus_dir_a: assert property (bus_mode |-> // RULE3
      pc_oe_o == {8{bus_write_i}} && pc_o == bus_wdata_i)
    else $error("port c bus drive wrong");
  dir_reset_a: assert property ($fell(rst_i) |-> // RULE19
      pj_oe_o == {timer2_oc_en_i, 3'b000} &&
      pk_oe_o == {timer3_oc_en_i, 3'b000} &&
      (io_mode -> pc_oe_o == 8'h00))
    else $error("pins driven after reset");
  c_open_drain_a: assert property (c_od |-> // RULE6
      pc_o == 8'h00 && (pc_oe_o & port_c_data_reg) == 8'h00)
    else $error("port c open drain drives high");
  c_od_single_a: assert property (io_mode && !single |-> // RULE7
      pc_oe_o == port_c_direction_reg)
    else $error("port c open drain outside single chip");
  d_open_drain_a: assert property (spi_pins_open_drain_en |-> // RULE9
      pd_o[5:2] == 4'h0)
    else $error("spi pins drive high in open drain");
  oc_owns_pin_a: assert property (wr && s_jd && timer2_oc_en_i[4] |=> // RULE18
      pj_o[7] == timer2_oc_i[4] || !timer2_oc_en_i[4])
    else $error("port j write moved compare pin");
  dir_write_a: assert property (wr && s_hr |=> // RULE20
      port_h_direction_reg == $past(wb))
    else $error("direction write lost");
  port_f_addr_a: assert property (bus_mode |-> // RULE12
      pf_o == bus_addr_i[7:0] && pf_oe_o == 8'hff)
    else $error("port f not carrying low address");
  g_exp_addr_a: assert property (g_exp[0] |-> // RULE14
      pg_o[0] == mem_expansion_addr_i[0] && pg_oe_o[0])
    else $error("port g expansion address missing");
  pwm_pin_a: assert property (pwm_en_i[0] |-> // RULE16
      ph_o[0] == pwm_i[0] && ph_oe_o[0])
    else $error("pwm not on port h pin");
  k_compare_pin_a: assert property (timer3_oc_en_i[4] |-> // RULE17
      pk_o[7] == timer3_oc_i[4] && pk_oe_o[7])
    else $error("timer not on port k pin");

endmodule : mpio_port_pins

// [test/mpio_pad_model.sv]
// Purpose: pad model for one 8-bit port of the pin logic
// Assumes: the design output wins over the external driver
// Notes:   an undriven pad without pull-up flips every cycle
`timescale 1ns/1ps
module mpio_pad_model (
  // clock
  input  wire logic       clk_i,
  // design side
  input  wire logic [7:0] o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pull_i,
  // external driver
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  // resolved pad level
  output logic [7:0]      lvl_o
);
  logic [7:0] float_q = 8'h55;

  // a floating pad must never look like a held value
  always @(posedge clk_i) float_q <= ~float_q;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_o[i] = oe_i[i] ? o_i[i] : ext_en_i[i] ? ext_i[i] :
                 pull_i[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : mpio_pad_model

// [test/testbench.sv]
// Purpose: self-checking bench for the multi port pin logic
// Assumes: pads resolved by mpio_pad_model, externals always driven
// Notes:   port order in arrays is b c d f g h j k
`timescale 1ns/1ps
module testbench;
  import mpio_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            mode_a = 1'b0;
  logic            mode_b = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [15:0]     bus_addr = 16'h0;
  logic [7:0]      bus_wdata = 8'h00;
  logic            bus_write = 1'b0;
  logic [5:0]      exp_addr = 6'h00;
  logic [7:0]      bus_rdata;
  logic [3:0]      cs_en = 4'h0;
  logic [3:0]      pwm_en = 4'h0;
  logic [4:0]      t2_en = 5'h00;
  logic [4:0]      t3_en = 5'h00;
  logic            spi_en = 1'b0;
  logic            sci_en = 1'b0;
  logic [7:0]      pe = 8'h00;
  logic [31:0]     rnd = 32'h0;
  logic [7:0][7:0] po;
  logic [7:0][7:0] poe;
  logic [7:0][7:0] plv;
  logic [7:0][7:0] ext = '0;
  logic [7:0][7:0] pul;
  logic [7:0]      pu_b;
  logic [7:0]      pu_f;
  logic [7:0]      pu_h;
  logic [5:0]      pu_g;
  logic [3:0]      mode;
  logic [31:0]     rd;
  logic            err_seen;
  int              n_errors = 0;
  int              checks_done = 0;
  logic [7:0]      doff [8] = '{OFF_B_DATA, OFF_C_DATA, OFF_D_DATA,
    OFF_F_DATA, OFF_G_DATA, OFF_H_DATA, OFF_J_DATA, OFF_K_DATA};

  always #2 clk = ~clk;
  always_comb pul = {16'h0, pu_h, {2'b00, pu_g}, pu_f, 16'h0, pu_b};

  mpio_port_pins i_dut (
    .clk_i(clk), .rst_i(rst), .mode_a_i(mode_a), .mode_b_i(mode_b),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
    .bus_write_i(bus_write), .mem_expansion_addr_i(exp_addr),
    .bus_rdata_o(bus_rdata),
    .spi_en_i(spi_en), .spi_out_i(rnd[3:0]), .spi_oe_i(rnd[7:4]),
    .sci_en_i(sci_en), .sci_out_i(rnd[9:8]), .sci_oe_i(rnd[11:10]),
    .chip_sel_en_i(cs_en), .chip_sel_i(rnd[15:12]),
    .pwm_en_i(pwm_en), .pwm_i(rnd[19:16]),
    .timer2_oc_en_i(t2_en), .timer2_oc_i(rnd[24:20]),
    .timer3_oc_en_i(t3_en), .timer3_oc_i(rnd[29:25]),
    .pb_i(plv[0]), .pb_o(po[0]), .pb_oe_o(poe[0]),
    .pc_i(plv[1]), .pc_o(po[1]), .pc_oe_o(poe[1]),
    .pd_i(plv[2]), .pd_o(po[2]), .pd_oe_o(poe[2]), .pe_i(pe),
    .pf_i(plv[3]), .pf_o(po[3]), .pf_oe_o(poe[3]),
    .pg_i(plv[4]), .pg_o(po[4]), .pg_oe_o(poe[4]),
    .ph_i(plv[5]), .ph_o(po[5]), .ph_oe_o(poe[5]),
    .pj_i(plv[6]), .pj_o(po[6]), .pj_oe_o(poe[6]),
    .pk_i(plv[7]), .pk_o(po[7]), .pk_oe_o(poe[7]),
    .pb_pullup_o(pu_b), .pf_pullup_o(pu_f), .ph_pullup_o(pu_h),
    .pg_pullup_o(pu_g), .mode_o(mode));

  for (genvar g = 0; g < 8; g++) begin : g_pad
    mpio_pad_model i_pad (.clk_i(clk), .o_i(po[g]), .oe_i(poe[g]),
      .pull_i(pul[g]), .ext_i(ext[g]), .ext_en_i(8'hff), .lvl_o(plv[g]));
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      $display("[ERR] %0t no ready", $time);
    end
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic b, input logic a);
    @(posedge clk);
    rst    <= 1'b1;
    mode_b <= b;
    mode_a <= a;
    repeat (3) @(posedge clk);
    rst    <= 1'b0;
    @(negedge clk);
  endtask : do_reset

  // pin level seen by a read: driven value on outputs, pad on inputs
  function automatic logic [7:0] pinx(logic [7:0] d, logic [7:0] r,
                                      logic [7:0] e);
    return (d & r) | (e & ~r);
  endfunction : pinx

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] r;
    int         i;
    logic [3:0] oh [4] = '{4'b0001, 4'b0100, 4'b0010, 4'b1000};
    rd = $urandom(55);
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      chk({4'h0, mode}, {4'h0, oh[m]});
      chk(poe[0] | poe[3], m[0] ? 8'hff : 8'h00);
      chk(poe[1] | poe[6] | poe[7], 8'h00);
    end
    // expanded mode: bus pins, expansion address, chip selects
    d = 8'($urandom);
    apb(1'b1, OFF_G_ASSIGN, 8'h3f);
    apb(1'b1, OFF_SYS_OPT, 8'h01);
    apb(1'b1, OFF_SPI_CTL, 8'h01);
    apb(1'b1, OFF_D_DIR, 8'hff);
    apb(1'b1, OFF_D_DATA, d);
    repeat (4) begin
      @(posedge clk);
      bus_addr  <= 16'($urandom);
      bus_wdata <= 8'($urandom);
      bus_write <= 1'b1;
      exp_addr  <= 6'($urandom);
      rnd       <= $urandom;
      cs_en     <= 4'hf;
      pwm_en    <= 4'hf;
      @(negedge clk);
      chk(po[0], bus_addr[15:8]);
      chk(po[3], bus_addr[7:0]);
      chk(po[1], bus_wdata);
      chk(poe[1], 8'hff);
      chk({2'b00, po[4][5:0]}, {2'b00, exp_addr});
      chk(poe[4] & 8'hc0, 8'h00);
      chk(po[5], {rnd[15:12], rnd[19:16]});
      chk(poe[2] & 8'h3c, ~d & 8'h3c);
      @(negedge clk);
      chk(bus_rdata, bus_wdata);
    end
    // single chip mode: data, direction and readback of every port
    do_reset(1'b1, 1'b0);
    @(posedge clk);
    cs_en  <= 4'h0;
    pwm_en <= 4'h0;
    for (int n = 0; n < 24; n++) begin
      i = n % 8;
      d = 8'($urandom);
      r = 8'($urandom);
      @(posedge clk);
      ext[i] <= 8'($urandom);
      apb(1'b1, doff[i], d);
      apb(1'b1, doff[i] + 8'h04, r);
      if (i == 4) r[7:6] = 2'b00;
      @(negedge clk);
      chk(poe[i], r);
      chk(po[i] & r, d & r);
      apb(1'b0, doff[i], 8'h00);
      chk(rd[7:0], pinx(d, r, ext[i]));
      apb(1'b0, doff[i] + 8'h04, 8'h00);
      chk(rd[7:0], r);
    end
    // open drain on c and d: reads still give the latch on outputs
    apb(1'b1, OFF_SYS_OPT, 8'h01);
    apb(1'b1, OFF_SPI_CTL, 8'h01);
    apb(1'b1, OFF_SCI_CTL, 8'h01);
    d = 8'($urandom);
    r = 8'($urandom);
    apb(1'b1, OFF_C_DATA, d);
    apb(1'b1, OFF_C_DIR, r);
    apb(1'b1, OFF_D_DATA, d);
    apb(1'b1, OFF_D_DIR, r);
    @(negedge clk);
    chk(poe[1], r & ~d);
    chk(po[1] & poe[1], 8'h00);
    chk(poe[2], r & ~(d & 8'h3f));
    apb(1'b0, OFF_C_DATA, 8'h00);
    chk(rd[7:0], pinx(d, r, ext[1]));
    apb(1'b0, OFF_D_DATA, 8'h00);
    chk(rd[7:0], pinx(d, r, ext[2]));
    // serial peripherals take port d 5:0, open drain still applies
    @(posedge clk);
    spi_en <= 1'b1;
    sci_en <= 1'b1;
    @(negedge clk);
    chk(po[2], {d[7:6], 6'h00});
    r = {r[7:6], rnd[7:4] & ~rnd[3:0], rnd[11:10] & ~rnd[9:8]};
    chk(poe[2], r);
    // timer compares own j/k 7:3, data writes only reach 2:0
    for (int k = 6; k < 8; k++) begin
      apb(1'b1, doff[k] + 8'h04, 8'hff);
      @(posedge clk);
      t2_en <= 5'h1f;
      t3_en <= 5'h1f;
      d = 8'($urandom);
      apb(1'b1, doff[k], d);
      @(negedge clk);
      r = {(k == 6) ? rnd[24:20] : rnd[29:25], 3'b000};
      chk(po[k] & 8'hf8, r);
      chk(po[k] & 8'h07, d & 8'h07);
    end
    @(posedge clk);
    pe <= 8'($urandom);
    apb(1'b0, OFF_E_DATA, 8'h00);
    chk(rd[7:0], pe);
    d = 8'($urandom);
    apb(1'b1, OFF_PULLUP, d);
    @(negedge clk);
    chk(pu_b, {8{d[POS_PU_B]}});
    chk(pu_f, {8{d[POS_PU_F]}});
    chk(pu_h, {8{d[POS_PU_H]}});
    chk({2'b00, pu_g}, {2'b00, {6{d[POS_PU_G]}}});
    // unmapped address answers with an error
    apb(1'b1, 8'hfc, 8'h5a);
    chk({7'h00, err_seen}, 8'h01);
    close_out();
  end
endmodule : testbench
